// *** hw/mas_alarm_top.sv ***
// Alarm status flags, masks and alarm pin driver of the hardware monitor.
// Assumes the serial engine gives single-cycle read and write strobes,
// and that limit checks deliver one-cycle violation pulses on mclk_i.
// Operation
// [RULE_01] Supply channels 0-3 set first flags bits 0-3
// [RULE_02] Temperature flag bit 4 follows selected mode
// [RULE_03] Fans set first flags bits 6 and 7
// [RULE_04] +12V and shared channel set second bits 0,1
// [RULE_05] Enclosure going high sets second bit 4
// [RULE_06] Status read clears flags; unused bits zero
// [RULE_07] Enclosure flag survives reads, cleared by control
// [RULE_08] Remaining violation re-raises alarm after service
// [RULE_09] First mask bits block matching first flags
// [RULE_10] Second mask bits 0,1,4 block second flags
// [RULE_11] Mask bit 7 gates remote reset control
// [RULE_12] Spare read-write byte, zero at power-up
// [RULE_13] Flags and masks power up as zero
// [RULE_14] Software masks a persistently faulty channel
// [RULE_15] Alarm pin driven only when enabled
// [RULE_16] Alarm clear bit drops pin, flags kept
// [RULE_17] Remote reset gives at least 20 ms pulse
// [RULE_18] Enclosure clear bit resets flag, self-clears
// [RULE_19] Alarm asserted for any unmasked set flag
`timescale 1ns/1ps
module mas_alarm_top
  import mas_pkg::*;
#(
  parameter int SYS_RST_CYC = MAS_SYS_RST_CYC
)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i, // Register address pointer
  input wire logic reg_wr_i, // Write strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, valid cycle after strobe
  input wire logic [5:0] supply_viol_i, // Supply limit violation pulses
  input wire logic [1:0] cooler_viol_i, // Fan count limit violation pulses
  input wire logic [1:0] temp_mode_i, // Temperature alarm mode select
  input wire logic temp_conv_done_i, // Temperature conversion done pulse
  input wire logic temp_above_hot_i, // Temperature above hot limit
  input wire logic temp_below_hyst_i, // Temperature below hysteresis
  input wire logic enclosure_switch_pin_i, // Intrusion pin, asynchronous
  output logic alarm_n_o, // Open-drain alarm pin, active low
  output logic alarm_oe_o, // Alarm pin drive enable
  output logic sys_rst_n_o, // Open-drain system reset, active low
  output logic sys_rst_oe_o, // System reset drive enable
  output logic monitor_start_o // Measurement loop run enable
);
  logic [7:0] cfg; // Configuration byte
  logic [7:0] flags_a; // First alarm flags
  logic [7:0] flags_b; // Second alarm flags
  logic [7:0] alarm_mask_a;
  logic [7:0] alarm_mask_b;
  logic [7:0] spare_byte;
  logic alarm_act; // Registered alarm state
  logic [7:0] next_cfg;
  logic [7:0] next_flags_a;
  logic [7:0] next_flags_b;
  logic [7:0] next_mask_a;
  logic [7:0] next_mask_b;
  logic [7:0] next_spare;
  logic next_alarm_act;
  logic [7:0] next_rdata;
  logic enc_s1; // Synchroniser first stage
  logic enc_s2; // Synchroniser second stage
  logic enc_d; // Delayed copy for rise detection
  logic enc_rise;
  logic [7:0] set_a; // Flag set events this cycle
  logic [7:0] set_b;
  logic [7:0] clr_a; // Flag clear requests this cycle
  logic [7:0] clr_b;
  logic [7:0] pend_a; // Unmasked pending flags
  logic [7:0] pend_b;
  logic new_evt; // An unmasked flag is being set
  logic status_rd; // Either status register is read
  logic soft_init; // Init bit written
  logic temp_set;
  logic temp_drop;
  logic rst_busy;

  // Register-access decode helpers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // Temperature event generator
  mas_temp_flag u_temp
  (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .mode_sel_i(temp_mode_i),
    .conv_done_i(temp_conv_done_i),
    .above_hot_i(temp_above_hot_i),
    .below_hyst_i(temp_below_hyst_i),
    .set_o(temp_set),
    .drop_o(temp_drop)
  );

  // Remote reset pulse timer
  mas_reset_pulse #(.PULSE_CYC(SYS_RST_CYC)) u_rst
  (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .req_i(cfg[MAS_CFG_SYS_RST]),
    .busy_o(rst_busy)
  );

  // Intrusion pin synchroniser; only enc_s2 and later are looked at
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      enc_s1 <= 1'b0;
      enc_s2 <= 1'b0;
      enc_d <= 1'b0;
    end
    else
    begin
      enc_s1 <= enclosure_switch_pin_i;
      enc_s2 <= enc_s1;
      enc_d <= enc_s2;
    end
  end

  assign enc_rise = enc_s2 & ~enc_d;

  // Flag events, clears and pending terms
  always_comb
  begin
    status_rd = reg_rd_i & (hit(reg_addr_i, MAS_FLAGS_A_ADDR) | hit(reg_addr_i, MAS_FLAGS_B_ADDR));
    soft_init = reg_wr_i & hit(reg_addr_i, MAS_CFG_ADDR) & reg_wdata_i[MAS_CFG_INIT];
    set_a = 8'h00;
    set_a[3:0] = supply_viol_i[3:0]; // RULE_01
    set_a[MAS_A_TEMP] = temp_set; // RULE_02
    set_a[MAS_A_COOLER1] = cooler_viol_i[0]; // RULE_03
    set_a[MAS_A_COOLER2] = cooler_viol_i[1]; // RULE_03
    set_b = 8'h00;
    set_b[MAS_B_RAIL12] = supply_viol_i[4]; // RULE_04
    set_b[MAS_B_NEG_OR_CPU2] = supply_viol_i[5]; // RULE_04
    set_b[MAS_B_ENCLOSURE] = enc_rise; // RULE_05
    // Reading clears what was read; the enclosure flag is spared
    clr_a = (reg_rd_i && hit(reg_addr_i, MAS_FLAGS_A_ADDR)) ? 8'hff : 8'h00; // RULE_06
    clr_a[MAS_A_TEMP] = clr_a[MAS_A_TEMP] | temp_drop; // RULE_02
    clr_b = (reg_rd_i && hit(reg_addr_i, MAS_FLAGS_B_ADDR)) ? 8'hff : 8'h00; // RULE_06
    clr_b[MAS_B_ENCLOSURE] = cfg[MAS_CFG_ENC_CLR]; // RULE_07 RULE_18
    pend_a = flags_a & ~alarm_mask_a; // RULE_09
    pend_b = flags_b & ~alarm_mask_b & MAS_B_USED; // RULE_10
    new_evt = |(set_a & ~alarm_mask_a & MAS_A_USED) | |(set_b & ~alarm_mask_b & MAS_B_USED);
  end

  // Register next values; a set in the clearing cycle wins
  always_comb
  begin
    next_flags_a = ((flags_a & ~clr_a) | set_a) & MAS_A_USED; // RULE_06
    next_flags_b = ((flags_b & ~clr_b) | set_b) & MAS_B_USED; // RULE_06
    next_mask_a = alarm_mask_a;
    next_mask_b = alarm_mask_b;
    next_spare = spare_byte;
    next_cfg = cfg;
    if (reg_wr_i && hit(reg_addr_i, MAS_MASK_A_ADDR))
    begin
      // Unused bit 5 is kept at zero
      next_mask_a = reg_wdata_i & MAS_A_USED; // RULE_09
    end
    if (reg_wr_i && hit(reg_addr_i, MAS_MASK_B_ADDR))
    begin
      next_mask_b = reg_wdata_i & (MAS_B_USED | 8'h80); // RULE_10
    end
    if (reg_wr_i && hit(reg_addr_i, MAS_SPARE_ADDR))
    begin
      next_spare = reg_wdata_i; // RULE_12
    end
    if (reg_wr_i && hit(reg_addr_i, MAS_CFG_ADDR))
    begin
      next_cfg = reg_wdata_i & MAS_CFG_WMASK;
      // Reset request only sticks while the mask register enables it
      next_cfg[MAS_CFG_SYS_RST] = reg_wdata_i[MAS_CFG_SYS_RST] & alarm_mask_b[MAS_B_RST_EN]; // RULE_11
    end
    // Request bit drops once the pulse is running
    if (rst_busy)
    begin
      next_cfg[MAS_CFG_SYS_RST] = 1'b0; // RULE_17
    end
    // Enclosure clear self-clears when the pin has gone low
    if (cfg[MAS_CFG_ENC_CLR] && !enc_s2)
    begin
      next_cfg[MAS_CFG_ENC_CLR] = 1'b0; // RULE_18
    end
    // A fresh unmasked event or a status read re-arms the alarm
    if (new_evt || status_rd)
    begin
      next_cfg[MAS_CFG_ALARM_CLR] = 1'b0; // RULE_08
    end
    if (soft_init)
    begin
      // Init restores the config, flag, mask and spare registers; alarm_act is left alone
      next_cfg = MAS_CFG_RST;
      next_flags_a = MAS_FLAGS_RST;
      next_flags_b = MAS_FLAGS_RST;
      next_mask_a = MAS_MASK_RST;
      next_mask_b = MAS_MASK_RST;
      next_spare = MAS_SPARE_RST;
    end
  end

  // Alarm and read data next values
  always_comb
  begin
    // Clear bit holds the pin off but leaves the flags alone
    next_alarm_act = cfg[MAS_CFG_ALARM_EN] & ~cfg[MAS_CFG_ALARM_CLR] & (|pend_a | |pend_b); // RULE_15 RULE_16 RULE_19
    next_rdata = 8'h00;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        MAS_CFG_ADDR: next_rdata = cfg;
        MAS_FLAGS_A_ADDR: next_rdata = flags_a;
        MAS_FLAGS_B_ADDR: next_rdata = flags_b;
        MAS_MASK_A_ADDR: next_rdata = alarm_mask_a;
        MAS_MASK_B_ADDR: next_rdata = alarm_mask_b;
        MAS_SPARE_ADDR: next_rdata = spare_byte;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Block registers apart from the intrusion pin synchroniser
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg <= MAS_CFG_RST;
      flags_a <= MAS_FLAGS_RST; // RULE_13
      flags_b <= MAS_FLAGS_RST; // RULE_13
      alarm_mask_a <= MAS_MASK_RST; // RULE_13
      alarm_mask_b <= MAS_MASK_RST; // RULE_13
      spare_byte <= MAS_SPARE_RST; // RULE_12
      alarm_act <= 1'b0;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      cfg <= next_cfg;
      flags_a <= next_flags_a;
      flags_b <= next_flags_b;
      alarm_mask_a <= next_mask_a;
      alarm_mask_b <= next_mask_b;
      spare_byte <= next_spare;
      alarm_act <= next_alarm_act;
      reg_rdata_o <= next_rdata;
    end
  end

  // Open-drain pins pull low only while active
  assign alarm_n_o = ~alarm_act;
  assign alarm_oe_o = alarm_act; // RULE_15
  assign sys_rst_n_o = ~rst_busy;
  assign sys_rst_oe_o = rst_busy;
  assign monitor_start_o = cfg[MAS_CFG_START];

  // A violation on supply channel 0 is latched on the next edge
  a_supply_set: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (supply_viol_i[0] && !soft_init) |=> flags_a[0]) // RULE_01
    else $error("supply violation did not set its flag");

  // Second fan violation is latched on the next edge
  a_cooler_set: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cooler_viol_i[1] && !soft_init) |=> flags_a[MAS_A_COOLER2]) // RULE_03
    else $error("fan violation did not set its flag");

  // A first status register read with no new event leaves nothing set
  a_read_clear: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == MAS_FLAGS_A_ADDR && set_a == 8'h00) |=> flags_a == 8'h00) // RULE_06
    else $error("status read left flags set");

  // Unused flag positions can never hold a one
  a_unused_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (flags_a & ~MAS_A_USED) == 8'h00 && (flags_b & ~MAS_B_USED) == 8'h00) // RULE_06
    else $error("unused flag bit set");

  // Only the clear control or init may drop the enclosure flag
  a_enclosure_keep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (flags_b[MAS_B_ENCLOSURE] && !cfg[MAS_CFG_ENC_CLR] && !soft_init) |=> flags_b[MAS_B_ENCLOSURE]) // RULE_07
    else $error("enclosure flag lost without its clear");

  // The pin is only pulled if the enable bit was on the cycle before
  a_enable_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    alarm_oe_o |-> $past(cfg[MAS_CFG_ALARM_EN])) // RULE_15
    else $error("alarm driven while disabled");

  // With the alarm enabled and not cleared, any unmasked flag pulls the pin one cycle later
  a_alarm_cause: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cfg[MAS_CFG_ALARM_EN] && !cfg[MAS_CFG_ALARM_CLR] && (pend_a != 8'h00 || pend_b != 8'h00))
    |=> !alarm_n_o && alarm_oe_o) // RULE_19
    else $error("unmasked flag did not raise alarm");

  // Quiet cycle only: masked events, a temperature drop or init may still move flags
  a_clear_drops: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == MAS_CFG_ADDR && reg_wdata_i[MAS_CFG_ALARM_CLR] && !new_evt && !status_rd)
    ##1 (!new_evt && !status_rd && !soft_init && set_a == 8'h00 && !temp_drop)
    |=> !alarm_act && flags_a == $past(flags_a)) // RULE_16
    else $error("alarm clear did not drop the pin");

  // Without the mask enable a reset request is never stored
  a_reset_gate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == MAS_CFG_ADDR && !alarm_mask_b[MAS_B_RST_EN]) |=> !cfg[MAS_CFG_SYS_RST]) // RULE_11
    else $error("reset request accepted while disabled");
endmodule

// *** hw/mas_pkg.sv ***
// Shared constants and types for the monitor alarm status and mask block.
// Assumes a byte-wide register port driven by the serial port engine.
package mas_pkg;
  // Register offsets on the byte register port
  localparam logic [7:0] MAS_CFG_ADDR = 8'h40;
  localparam logic [7:0] MAS_FLAGS_A_ADDR = 8'h41;
  localparam logic [7:0] MAS_FLAGS_B_ADDR = 8'h42;
  localparam logic [7:0] MAS_MASK_A_ADDR = 8'h43;
  localparam logic [7:0] MAS_MASK_B_ADDR = 8'h44;
  localparam logic [7:0] MAS_SPARE_ADDR = 8'h45;
  // Reset values
  localparam logic [7:0] MAS_CFG_RST = 8'h08;
  localparam logic [7:0] MAS_FLAGS_RST = 8'h00;
  localparam logic [7:0] MAS_MASK_RST = 8'h00;
  localparam logic [7:0] MAS_SPARE_RST = 8'h00;
  // Configuration field positions
  localparam int MAS_CFG_START = 0;
  localparam int MAS_CFG_ALARM_EN = 1;
  localparam int MAS_CFG_ALARM_CLR = 3;
  localparam int MAS_CFG_SYS_RST = 4;
  localparam int MAS_CFG_ENC_CLR = 6;
  localparam int MAS_CFG_INIT = 7;
  // Flag field positions and the second mask's reset enable bit
  localparam int MAS_A_TEMP = 4;
  localparam int MAS_A_COOLER1 = 6;
  localparam int MAS_A_COOLER2 = 7;
  localparam int MAS_B_RAIL12 = 0;
  localparam int MAS_B_NEG_OR_CPU2 = 1;
  localparam int MAS_B_ENCLOSURE = 4;
  localparam int MAS_B_RST_EN = 7;
  // Bits that exist in each flag register; others read as zero
  localparam logic [7:0] MAS_A_USED = 8'hdf;
  localparam logic [7:0] MAS_B_USED = 8'h13;
  // Writable bits of the configuration register (init bit self-clears)
  localparam logic [7:0] MAS_CFG_WMASK = 8'h7f;
  // Remote reset pulse timing
  localparam int MAS_CLK_PERIOD_PS = 4000;
  localparam int MAS_SYS_RST_MS = 20;
  // Worked in nanoseconds so that the product stays inside a 32-bit int
  localparam int MAS_SYS_RST_CYC = (MAS_SYS_RST_MS * 1000000) / (MAS_CLK_PERIOD_PS / 1000);
  localparam int MAS_RST_CNT_W = 23;
  // Temperature alarm modes
  typedef enum logic [1:0] {MAS_TM_DEFAULT, MAS_TM_ONESHOT, MAS_TM_COMPARE} mas_tmode_t;
  // Decode the two mode select bits
  function automatic mas_tmode_t mas_tmode(input logic [1:0] sel);
    mas_tmode_t m;
    m = MAS_TM_DEFAULT;
    if (sel == 2'h1)
    begin
      m = MAS_TM_ONESHOT;
    end
    else if (sel == 2'h2)
    begin
      m = MAS_TM_COMPARE;
    end
    return m;
  endfunction
endpackage

// *** hw/mas_temp_flag.sv ***
// Temperature flag event generator for the three temperature alarm modes.
// Assumes comparison results are valid in the cycle of conv_done_i.
`timescale 1ns/1ps
module mas_temp_flag
  import mas_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mode_sel_i, // Mode select bits
  input wire logic conv_done_i, // One-cycle pulse per conversion
  input wire logic above_hot_i, // Reading above hot limit
  input wire logic below_hyst_i, // Reading below hysteresis limit
  output logic set_o, // Pulse: set the temperature flag
  output logic drop_o // Pulse: clear the flag (comparator mode)
);
  logic hot_active; // Default mode: between hot and hysteresis
  logic armed; // One-shot mode: next hot crossing may fire
  logic next_hot_active;
  logic next_armed;
  mas_tmode_t mode;

  // Event and state next values per mode
  always_comb
  begin
    mode = mas_tmode(mode_sel_i);
    set_o = 1'b0;
    drop_o = 1'b0;
    next_hot_active = hot_active;
    next_armed = armed;
    if (conv_done_i)
    begin
      unique case (mode)
        MAS_TM_DEFAULT:
        begin
          // Repeats every conversion until below hysteresis
          set_o = above_hot_i | (hot_active & ~below_hyst_i); // RULE_02
          next_hot_active = above_hot_i | (hot_active & ~below_hyst_i);
        end
        MAS_TM_ONESHOT:
        begin
          // One event on the way up, one on the way back down
          set_o = (above_hot_i & armed) | (below_hyst_i & ~armed); // RULE_02
          if (above_hot_i & armed)
          begin
            next_armed = 1'b0;
          end
          else if (below_hyst_i)
          begin
            next_armed = 1'b1;
          end
        end
        MAS_TM_COMPARE:
        begin
          // No hysteresis: follows the hot limit directly
          set_o = above_hot_i; // RULE_02
          drop_o = ~above_hot_i;
        end
      endcase
    end
  end

  // Mode state registers
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hot_active <= 1'b0;
      armed <= 1'b1;
    end
    else
    begin
      hot_active <= next_hot_active;
      armed <= next_armed;
    end
  end

  // Comparator mode raises the flag on every hot conversion
  a_comp_set: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (mode_sel_i == 2'h2 && conv_done_i && above_hot_i) |-> set_o && !drop_o) // RULE_02
    else $error("comparator mode missed a hot conversion");
endmodule

// *** hw/mas_reset_pulse.sv ***
// Remote system reset pulse timer.
// Assumes req_i stays high until busy_o is seen, then drops.
`timescale 1ns/1ps
module mas_reset_pulse
  import mas_pkg::*;
#(
  parameter int PULSE_CYC = MAS_SYS_RST_CYC
)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic req_i, // Level: pulse requested
  output logic busy_o // Level: pulse active
);
  typedef enum {MAS_RP_IDLE, MAS_RP_PULSE} mas_rp_state_t;
  mas_rp_state_t state;
  mas_rp_state_t next_state;
  logic [MAS_RST_CNT_W-1:0] cnt; // Cycles spent in the pulse
  logic [MAS_RST_CNT_W-1:0] next_cnt;
  localparam logic [MAS_RST_CNT_W-1:0] LAST = MAS_RST_CNT_W'(PULSE_CYC - 1);

  // Pulse sequencing
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      MAS_RP_IDLE:
      begin
        if (req_i)
        begin
          next_state = MAS_RP_PULSE;
          next_cnt = '0;
        end
      end
      MAS_RP_PULSE:
      begin
        // Held for the full minimum width, never cut short
        if (cnt == LAST)
        begin
          next_state = MAS_RP_IDLE;
        end
        else
        begin
          next_cnt = cnt + 1'b1; // RULE_17
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= MAS_RP_IDLE;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign busy_o = (state == MAS_RP_PULSE);

  // Pulse lasts at least eight cycles even with a shortened count
  a_pulse_width: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(busy_o) |-> busy_o [*8]) // RULE_17
    else $error("reset pulse shorter than expected");
endmodule

// *** dv/mas_host_model.sv ***
// Host side of the alarm and system reset pins: the interrupt input and the reset input.
// Assumes both pins are open drain with a board pull-up. Only the device pulls them low.
`timescale 1ns/1ps
module mas_host_model
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic alarm_n_i, // Alarm pin level driven by the device
  input wire logic alarm_oe_i, // Device pulls the alarm pin
  input wire logic sys_rst_n_i, // Reset pin level driven by the device
  input wire logic sys_rst_oe_i, // Device pulls the reset pin
  output logic alarm_line_o, // Resolved alarm wire seen by the host
  output logic rst_line_o, // Resolved reset wire seen by the host
  output logic [7:0] irq_count_o // Falling edges seen on the alarm wire
);
  logic alarm_q; // Last sampled alarm wire

  // An undriven pin floats to the pull-up, never to the last driven level
  assign alarm_line_o = alarm_oe_i ? alarm_n_i : 1'b1;
  assign rst_line_o = sys_rst_oe_i ? sys_rst_n_i : 1'b1;

  // The host input is edge sensitive, so it counts every new low level
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      alarm_q <= 1'b1;
      irq_count_o <= 8'h00;
    end
    else
    begin
      alarm_q <= alarm_line_o;
      if (alarm_q && !alarm_line_o)
      begin
        irq_count_o <= irq_count_o + 8'h01;
      end
    end
  end
endmodule

// *** dv/mas_alarm_top_tb.sv ***
// Self-checking bench for the alarm status and mask block.
// Drives the byte register port and event pulses at the falling clock edge.
`timescale 1ns/1ps
module mas_alarm_top_tb;
  import mas_pkg::*;
  localparam int RST_CYC = 16; // Short reset pulse keeps the run brief
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [5:0] supply_viol_i = 6'h00;
  logic [1:0] cooler_viol_i = 2'h0;
  logic [1:0] temp_mode_i = 2'h0;
  logic temp_conv_done_i = 1'b0;
  logic temp_above_hot_i = 1'b0;
  logic temp_below_hyst_i = 1'b0;
  logic enclosure_switch_pin_i = 1'b0;
  logic alarm_n_o, alarm_oe_o, sys_rst_n_o, sys_rst_oe_o, monitor_start_o;
  logic alarm_line, rst_line; // Resolved wires from the host model
  logic [7:0] irq_count; // Alarm edges seen by the host
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n; // Cycle counter for the reset pulse

  always #2 mclk_i = ~mclk_i;

  mas_alarm_top #(.SYS_RST_CYC(RST_CYC)) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .supply_viol_i(supply_viol_i), .cooler_viol_i(cooler_viol_i), .temp_mode_i(temp_mode_i),
    .temp_conv_done_i(temp_conv_done_i), .temp_above_hot_i(temp_above_hot_i),
    .temp_below_hyst_i(temp_below_hyst_i), .enclosure_switch_pin_i(enclosure_switch_pin_i),
    .alarm_n_o(alarm_n_o), .alarm_oe_o(alarm_oe_o), .sys_rst_n_o(sys_rst_n_o),
    .sys_rst_oe_o(sys_rst_oe_o), .monitor_start_o(monitor_start_o));

  mas_host_model host_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .alarm_n_i(alarm_n_o), .alarm_oe_i(alarm_oe_o),
    .sys_rst_n_i(sys_rst_n_o), .sys_rst_oe_i(sys_rst_oe_o), .alarm_line_o(alarm_line),
    .rst_line_o(rst_line), .irq_count_o(irq_count));

  // Verdict and end of run, shared by the main sequence and the timeout
  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare one byte seen against the value expected
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One write strobe, held for exactly one rising edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask

  // One read strobe; data stands in the cycle after the taking edge
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask

  // One-cycle violation pulse on one of the eight event sources
  task ev(input int i);
    @(negedge mclk_i);
    if (i < 6) supply_viol_i[i] = 1'b1;
    else cooler_viol_i[i-6] = 1'b1;
    @(negedge mclk_i);
    supply_viol_i = 6'h00;
    cooler_viol_i = 2'h0;
  endtask

  // One temperature conversion with the given comparison results
  task conv(input logic hot, input logic hyst);
    @(negedge mclk_i);
    temp_above_hot_i = hot;
    temp_below_hyst_i = hyst;
    temp_conv_done_i = 1'b1;
    @(negedge mclk_i);
    temp_conv_done_i = 1'b0;
  endtask

  // Alarm wire is checked two cycles on, after the flag and pin stages
  task alarm_is(input logic exp);
    repeat (2) @(negedge mclk_i);
    chk({7'h00, alarm_line}, {7'h00, exp});
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(negedge mclk_i);
    nrst_i = 1'b1;
    // Power-up values, spare byte and an unmapped address
    rd(MAS_CFG_ADDR, MAS_CFG_RST);
    for (int a = 8'h41; a <= 8'h45; a++) rd(a[7:0], 8'h00);
    rd(8'h50, 8'h00);
    chk({6'h00, alarm_line, monitor_start_o}, 8'h02);
    $display("test reset done");
    // Reserved mask bits, spare byte and read-only flags
    wr(MAS_MASK_A_ADDR, 8'hff);
    rd(MAS_MASK_A_ADDR, 8'hdf);
    wr(MAS_MASK_B_ADDR, 8'hff);
    rd(MAS_MASK_B_ADDR, 8'h93);
    wr(MAS_SPARE_ADDR, 8'ha5);
    rd(MAS_SPARE_ADDR, 8'ha5);
    wr(MAS_FLAGS_A_ADDR, 8'hff);
    rd(MAS_FLAGS_A_ADDR, 8'h00);
    wr(MAS_MASK_A_ADDR, 8'h00);
    wr(MAS_MASK_B_ADDR, 8'h00);
    $display("test access done");
    // Every event source lands in its own bit; a read clears it
    for (int i = 0; i < 8; i++)
    begin
      ev(i);
      if (i == 4 || i == 5)
      begin
        rd(MAS_FLAGS_B_ADDR, 8'h01 << (i - 4));
        rd(MAS_FLAGS_B_ADDR, 8'h00);
      end
      else
      begin
        rd(MAS_FLAGS_A_ADDR, 8'h01 << i);
        rd(MAS_FLAGS_A_ADDR, 8'h00);
      end
    end
    alarm_is(1'b1);
    $display("test flags done");
    // Alarm raise, mask, clear and re-raise
    wr(MAS_CFG_ADDR, 8'h02);
    ev(0);
    alarm_is(1'b0);
    wr(MAS_MASK_A_ADDR, 8'h01);
    alarm_is(1'b1);
    wr(MAS_MASK_A_ADDR, 8'h00);
    alarm_is(1'b0);
    wr(MAS_CFG_ADDR, 8'h0a);
    alarm_is(1'b1);
    rd(MAS_FLAGS_A_ADDR, 8'h01);
    ev(0);
    ev(2);
    alarm_is(1'b0);
    wr(MAS_CFG_ADDR, 8'h0a);
    alarm_is(1'b1);
    ev(2);
    alarm_is(1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h05);
    alarm_is(1'b1);
    // Four raises: first event, unmask, after the read, after the second clear
    chk(irq_count, 8'h04);
    // Software masks an errant +12 V channel
    wr(MAS_MASK_B_ADDR, 8'h01);
    ev(4);
    alarm_is(1'b1);
    rd(MAS_FLAGS_B_ADDR, 8'h01);
    wr(MAS_MASK_B_ADDR, 8'h00);
    $display("test alarm done");
    // Enclosure flag survives reads and clears only by its control bit
    enclosure_switch_pin_i = 1'b1;
    alarm_is(1'b1);
    alarm_is(1'b0);
    rd(MAS_FLAGS_B_ADDR, 8'h10);
    rd(MAS_FLAGS_B_ADDR, 8'h10);
    wr(MAS_MASK_B_ADDR, 8'h10);
    alarm_is(1'b1);
    wr(MAS_CFG_ADDR, 8'h42);
    rd(MAS_FLAGS_B_ADDR, 8'h00);
    enclosure_switch_pin_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    rd(MAS_CFG_ADDR, 8'h02);
    wr(MAS_MASK_B_ADDR, 8'h00);
    $display("test enclosure done");
    // Temperature flag in default, one-shot and comparator modes
    conv(1'b1, 1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h10);
    conv(1'b0, 1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h10);
    conv(1'b0, 1'b1);
    rd(MAS_FLAGS_A_ADDR, 8'h00);
    temp_mode_i = 2'h1;
    conv(1'b1, 1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h10);
    conv(1'b1, 1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h00);
    conv(1'b0, 1'b1);
    rd(MAS_FLAGS_A_ADDR, 8'h10);
    temp_mode_i = 2'h2;
    conv(1'b1, 1'b0);
    conv(1'b0, 1'b0);
    rd(MAS_FLAGS_A_ADDR, 8'h00);
    $display("test temperature done");
    // Remote reset is gated by mask bit 7 and lasts the set count
    wr(MAS_CFG_ADDR, 8'h12);
    rd(MAS_CFG_ADDR, 8'h02);
    chk({7'h00, rst_line}, 8'h01);
    wr(MAS_MASK_B_ADDR, 8'h80);
    wr(MAS_CFG_ADDR, 8'h12);
    n = 0;
    for (int w = 0; w < 10 && rst_line; w++) @(negedge mclk_i);
    while (!rst_line && n < 100)
    begin
      n++;
      @(negedge mclk_i);
    end
    chk(n[7:0], RST_CYC[7:0]);
    rd(MAS_CFG_ADDR, 8'h02);
    $display("test remote reset done");
    // Init bit restores the power-up values of the spare, second mask and config registers
    wr(MAS_CFG_ADDR, 8'h80);
    rd(MAS_SPARE_ADDR, 8'h00);
    rd(MAS_MASK_B_ADDR, 8'h00);
    rd(MAS_CFG_ADDR, MAS_CFG_RST);
    $display("test init done");
    close_out();
  end
endmodule
